// file: hdl/can_flag_map.svh
// Register map constants for the CAN event flag bank.
// Assumes inclusion by the package and the modules of this block only.
`ifndef CAN_FLAG_MAP_SVH
`define CAN_FLAG_MAP_SVH
// =============================================================
// Register offsets (byte addresses).
`define OFS_CAN_EVENT_FLAGS 4'h0
`define OFS_PERIPHERAL_ENABLE_ONE 4'h4
`define OFS_CAN_EVENT_MASK 4'h8
// =============================================================
// Flag bit positions.
`define BIT_INVALID_MESSAGE 7
`define BIT_BUS_WAKE 6
`define BIT_CAN_ERROR 5
`define BIT_TX_BUFFER2_DONE 4
`define BIT_TX_BUFFER1_DONE 3
`define BIT_TX_BUFFER0_DONE 2
`define BIT_RX_BUFFER1_FULL 1
`define BIT_RX_BUFFER0_FULL 0
// =============================================================
// Reset values.
`define RST_CAN_EVENT_FLAGS 8'h00
`define RST_PERIPHERAL_ENABLE_ONE 8'h00
`define RST_CAN_EVENT_MASK 8'h00
`endif

// file: hdl/can_flag_pkg.sv
// Types shared by the CAN event flag bank.
// Assumes the map header sits beside it.
`include "can_flag_map.svh"
package can_flag_pkg;
  typedef logic [7:0] byte_reg_t;
  typedef enum logic [1:0] {
    HTRANS_IDLE = 2'b00,
    HTRANS_BUSY = 2'b01,
    HTRANS_NONSEQ = 2'b10,
    HTRANS_SEQ = 2'b11
  } htrans_t;
endpackage : can_flag_pkg

// file: hdl/flag_sync.sv
// Two-stage synchroniser for a bundle of event levels with rising-edge pulses out.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module flag_sync
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Events.
  input wire logic [7:0] eventIn,
  output logic [7:0] eventPulse
);
  logic [7:0] stageOne;
  logic [7:0] stageTwo;
  logic [7:0] stageThree;
  // =============================================================
  // Synchroniser and edge detector.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stageOne <= 8'h00;
      stageTwo <= 8'h00;
      stageThree <= 8'h00;
    end
    else
    begin
      stageOne <= eventIn;
      stageTwo <= stageOne;
      stageThree <= stageTwo;
    end
  end
  assign eventPulse = stageTwo & ~stageThree;
endmodule : flag_sync
`default_nettype wire

// file: hdl/can_interrupt_flag_bank.sv
// CAN event flag bank with enables and AHB-Lite register slave.
// Assumes the CAN engine raises event levels asynchronous to sys_clk.
// Notes on behaviour
// - Invalid message on the bus sets flag bit 7.
// - Any bus activity sets the wake flag at bit 6.
// - Any CAN error source sets the single error flag at bit 5.
// - Transmit buffer 2, 1, 0 completion sets bits 4, 3, 2.
// - Receive buffer 1, 0 new message sets bits 1, 0.
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "can_flag_map.svh"
module can_interrupt_flag_bank
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire can_flag_pkg::htrans_t htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // CAN engine events.
  input wire logic invalidMessage,
  input wire logic busActivity,
  input wire logic [3:0] canErrorSources,
  input wire logic [2:0] txBufferDone,
  input wire logic [1:0] rxBufferFull,
  // Interrupt.
  output logic canIrq,
  output logic [7:0] peripheralIrqEnable
);
  import can_flag_pkg::*;
  byte_reg_t canEventFlags;
  byte_reg_t peripheralEnableOne;
  byte_reg_t canEventMask;
  logic [7:0] rawEvents;
  logic [7:0] eventPulse;
  logic wrPending;
  logic [3:0] wrAddr;
  logic [3:0] rdAddr;
  logic rdPending;
  byte_reg_t clearMask;
  byte_reg_t next_canEventFlags;
  byte_reg_t next_peripheralEnableOne;
  byte_reg_t next_canEventMask;
  logic irqPending;
  logic takeNow;
  // =============================================================
  // Register address decode and read word forming.
  function automatic logic regHit(input logic [3:0] addr, input logic [3:0] ofs);
    regHit = (addr == ofs);
  endfunction : regHit
  function automatic logic [31:0] padByte(input byte_reg_t value);
    padByte = {24'h00_0000, value};
  endfunction : padByte
  // =============================================================
  // Event gathering.
  function automatic logic anyOf(input logic [3:0] src);
    anyOf = |src;
  endfunction : anyOf
  always_comb
  begin
    rawEvents = 8'h00;
    rawEvents[`BIT_INVALID_MESSAGE] = invalidMessage;
    rawEvents[`BIT_BUS_WAKE] = busActivity;
    rawEvents[`BIT_CAN_ERROR] = anyOf(canErrorSources);
    rawEvents[`BIT_TX_BUFFER2_DONE] = txBufferDone[2];
    rawEvents[`BIT_TX_BUFFER1_DONE] = txBufferDone[1];
    rawEvents[`BIT_TX_BUFFER0_DONE] = txBufferDone[0];
    rawEvents[`BIT_RX_BUFFER1_FULL] = rxBufferFull[1];
    rawEvents[`BIT_RX_BUFFER0_FULL] = rxBufferFull[0];
  end
  // =============================================================
  // Events pass two flip-flops before the edge detector.
  flag_sync eventSync
  (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .eventIn(rawEvents),
    .eventPulse(eventPulse)
  );
  // =============================================================
  // Bus address phase capture.
  function automatic logic takeXfer(input logic sel, input htrans_t tr, input logic rdy);
    takeXfer = sel && rdy && (tr == HTRANS_NONSEQ || tr == HTRANS_SEQ);
  endfunction : takeXfer
  assign takeNow = takeXfer(hsel, htrans, hready);
  // =============================================================
  // Data phase kind, one cycle after the address phase.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPending <= 1'b0;
      rdPending <= 1'b0;
    end
    else if (hready)
    begin
      wrPending <= takeNow && hwrite;
      rdPending <= takeNow && !hwrite;
    end
  end
  // =============================================================
  // Data phase address.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrAddr <= 4'h0;
      rdAddr <= 4'h0;
    end
    else if (hready)
    begin
      wrAddr <= haddr[3:0];
      rdAddr <= haddr[3:0];
    end
  end
  // =============================================================
  // Bus response: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // =============================================================
  // Flag register: set wins over write-one-to-clear.
  always_comb
  begin
    clearMask = 8'h00;
    if (wrPending && regHit(wrAddr, `OFS_CAN_EVENT_FLAGS))
    begin
      clearMask = hwdata[7:0];
    end
  end
  always_comb
  begin
    next_canEventFlags = (canEventFlags & ~clearMask) | eventPulse;
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      canEventFlags <= `RST_CAN_EVENT_FLAGS;
    end
    else
    begin
      canEventFlags <= next_canEventFlags;
    end
  end
  // =============================================================
  // Next values of the enable and mask registers.
  always_comb
  begin
    next_peripheralEnableOne = peripheralEnableOne;
    next_canEventMask = canEventMask;
    if (wrPending && regHit(wrAddr, `OFS_PERIPHERAL_ENABLE_ONE))
    begin
      next_peripheralEnableOne = hwdata[7:0];
    end
    if (wrPending && regHit(wrAddr, `OFS_CAN_EVENT_MASK))
    begin
      next_canEventMask = hwdata[7:0];
    end
  end
  // =============================================================
  // Peripheral enable register.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      peripheralEnableOne <= `RST_PERIPHERAL_ENABLE_ONE;
    end
    else
    begin
      peripheralEnableOne <= next_peripheralEnableOne;
    end
  end
  // =============================================================
  // CAN event mask register.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      canEventMask <= `RST_CAN_EVENT_MASK;
    end
    else
    begin
      canEventMask <= next_canEventMask;
    end
  end
  assign peripheralIrqEnable = peripheralEnableOne;
  // =============================================================
  // Interrupt output.
  assign irqPending = |(canEventFlags & canEventMask);
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      canIrq <= 1'b0;
    end
    else
    begin
      canIrq <= irqPending;
    end
  end
  // =============================================================
  // Read data.
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (rdPending)
    begin
      case (rdAddr)
        `OFS_CAN_EVENT_FLAGS: hrdata = padByte(canEventFlags);
        `OFS_PERIPHERAL_ENABLE_ONE: hrdata = padByte(peripheralEnableOne);
        `OFS_CAN_EVENT_MASK: hrdata = padByte(canEventMask);
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end
endmodule : can_interrupt_flag_bank
`default_nettype wire

// file: tb/can_engine_model.sv
// CAN engine stand-in that raises event levels when told to by the bench.
// Assumes the bench holds a fire bit for at least one cycle.
`timescale 1ns/1ps
`default_nettype none
module can_engine_model
(
  // Control.
  input wire logic sys_clk,
  input wire logic [7:0] fire,
  input wire logic [3:0] errPick,
  // Events.
  output var logic invalidMessage = 1'b0,
  output var logic busActivity = 1'b0,
  output var logic [3:0] canErrorSources = 4'h0,
  output var logic [2:0] txBufferDone = 3'h0,
  output var logic [1:0] rxBufferFull = 2'h0
);
  // ==========
  // Levels follow the fire bits.
  always @(posedge sys_clk) invalidMessage <= fire[7];
  always @(posedge sys_clk) busActivity <= fire[6];
  always @(posedge sys_clk) canErrorSources <= fire[5] ? errPick : 4'h0;
  always @(posedge sys_clk) txBufferDone <= fire[4:2];
  always @(posedge sys_clk) rxBufferFull <= fire[1:0];
endmodule : can_engine_model
`default_nettype wire

// file: tb/can_interrupt_flag_bank_checker.sv
// Bus and enable register checks for the CAN flag bank.
// Assumes it is bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module can_interrupt_flag_bank_checker
(
  // Ports watched.
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire can_flag_pkg::htrans_t htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic canIrq,
  input wire logic [7:0] peripheralIrqEnable
);
  import can_flag_pkg::*;
  // ==========
  // Data phase trackers.
  logic wrEn;
  logic rdEn;
  logic rdAny;
  wire logic take = hsel && hreadyout && htrans == HTRANS_NONSEQ;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) wrEn <= 1'b0;
    else wrEn <= take && hwrite && haddr[3:0] == 4'h4;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) rdEn <= 1'b0;
    else rdEn <= take && !hwrite && haddr[3:0] == 4'h4;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) rdAny <= 1'b0;
    else rdAny <= take && !hwrite;
  a_enable_write: assert property (wrEn |=> peripheralIrqEnable == $past(hwdata[7:0]))
    else $error("enable write lost");
  a_enable_read: assert property (rdEn |-> hrdata == {24'h0, peripheralIrqEnable})
    else $error("enable read wrong");
  a_upper_zero: assert property (rdAny |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_idle_zero: assert property (!rdAny |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not okay");
  a_irq_reset_low: assert property ($rose(reset_n) |-> !canIrq)
    else $error("interrupt high after reset");
endmodule : can_interrupt_flag_bank_checker
bind can_interrupt_flag_bank can_interrupt_flag_bank_checker i_can_interrupt_flag_bank_checker
  (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hrdata, .hreadyout, .hresp,
   .canIrq, .peripheralIrqEnable);
`default_nettype wire

// file: tb/can_interrupt_flag_bank_tb.sv
// Self-checking bench for the CAN flag bank.
// Assumes the engine model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module can_interrupt_flag_bank_tb;
  import can_flag_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  htrans_t htrans = HTRANS_IDLE;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, canIrq, invalidMessage, busActivity;
  logic [3:0] canErrorSources;
  logic [2:0] txBufferDone;
  logic [1:0] rxBufferFull;
  logic [7:0] peripheralIrqEnable;
  logic [7:0] fire = 8'h0;
  logic [3:0] errPick = 4'h4;
  int failures = 0;
  int check_count = 0;
  always #2.5 sys_clk = ~sys_clk;
  can_engine_model i_can_engine_model (.sys_clk, .fire, .errPick, .invalidMessage, .busActivity,
    .canErrorSources, .txBufferDone, .rxBufferFull);
  can_interrupt_flag_bank i_can_interrupt_flag_bank (.sys_clk, .reset_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .invalidMessage,
    .busActivity, .canErrorSources, .txBufferDone, .rxBufferFull, .canIrq, .peripheralIrqEnable);
  // ==========
  // Bus cycle, compare and close.
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // ==========
  // Scenarios.
  task t_regs;
    for (int a = 0; a < 16; a += 4)
    begin
      bus(1'b0, a, 32'h0);
      chk("reset read", 32'h0, rd);
    end
    bus(1'b1, 32'h4, 32'hFFFF_FFA5);
    bus(1'b0, 32'h4, 32'h0);
    chk("enable", 32'hA5, rd);
    chk("enable port", 32'hA5, {24'h0, peripheralIrqEnable});
    bus(1'b1, 32'hC, 32'hFF);
    bus(1'b0, 32'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask : t_regs
  task t_events;
    for (int i = 0; i < 8; i++)
    begin
      fire <= 8'h1 << i;
      repeat (2) @(posedge sys_clk);
      fire <= 8'h0;
      repeat (6) @(posedge sys_clk);
      bus(1'b0, 32'h0, 32'h0);
      chk("flag", 32'h1 << i, rd);
      chk("masked irq", 32'h0, {31'h0, canIrq});
      bus(1'b1, 32'h8, 32'h1 << i);
      repeat (2) @(posedge sys_clk);
      chk("irq", 32'h1, {31'h0, canIrq});
      bus(1'b1, 32'h0, 32'h1 << i);
      repeat (2) @(posedge sys_clk);
      chk("cleared irq", 32'h0, {31'h0, canIrq});
      bus(1'b0, 32'h0, 32'h0);
      chk("cleared flag", 32'h0, rd);
      bus(1'b1, 32'h8, 32'h0);
    end
  endtask : t_events
  task t_errors;
    for (int j = 0; j < 4; j++)
    begin
      errPick <= 4'h1 << j;
      fire <= 8'h20;
      repeat (2) @(posedge sys_clk);
      fire <= 8'h00;
      repeat (6) @(posedge sys_clk);
      bus(1'b0, 32'h0, 32'h0);
      chk("error source flag", 32'h20, rd);
      bus(1'b1, 32'h0, 32'h20);
    end
  endtask : t_errors
  task t_set_wins;
    fire <= 8'h01;
    repeat (2) @(posedge sys_clk);
    fire <= 8'h00;
    repeat (6) @(posedge sys_clk);
    fire <= 8'h01;
    repeat (2) @(posedge sys_clk);
    fire <= 8'h00;
    bus(1'b1, 32'h0, 32'h1);
    bus(1'b0, 32'h0, 32'h0);
    chk("set wins over clear", 32'h1, rd);
    bus(1'b1, 32'h0, 32'h1);
    bus(1'b0, 32'h0, 32'h0);
    chk("flag after clear", 32'h0, rd);
  endtask : t_set_wins
  initial
  begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_events();
    t_errors();
    t_set_wins();
    test_done();
  end
  initial
  begin
    #20000;
    failures++;
    test_done();
  end
endmodule : can_interrupt_flag_bank_tb
`default_nettype wire
